// ==== design/pwbi_burst_input.sv ====
`timescale 1ns/100ps

// Function
// - Save program counter as re-entry address
// - Word count held as transfer down-counter
// - Pending interrupt while waiting takes exit path
// - Repeat ready test until data ready
// - First address to M, next to P
// - Check each write against fence and mapping
// - Bus-enable strobe per word drives data in
// - Captured word written at M address
// - Per word: count down, M from P, P up
// - Loop while count non-zero, else finish
// - Fetch next instruction from saved address
// - Finish: address after last word in B, A zero
// - Interrupt: restore re-entry address, hand off
// - Strobe high while device drives bus
module pwbi_burst_input (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        reset_n,
   // Burst request from the instruction decoder
   input  wire logic        burstStart,
   input  wire logic [15:0] pcIn,
   input  wire logic [15:0] accAIn,
   input  wire logic [15:0] accBIn,
   input  wire logic        intPending,
   // Memory protection
   input  wire logic [15:0] fenceAddr,
   input  wire logic        mapViolation,
   // Port pins
   input  wire logic        portDataReady_n,
   input  wire logic [15:0] portBusIn,
   output logic             portBusEnableStrobe,
   // Memory write side
   output logic             memWrite,
   input  wire logic        memReady,
   output logic [15:0]      memAddr,
   output logic [15:0]      memData,
   // Results
   output logic             busy,
   output logic [15:0]      accAOut,
   output logic [15:0]      accBOut,
   output logic [15:0]      pcOut,
   output logic             fetchReq,
   output logic [15:0]      fetchAddr,
   output logic             intExit,
   output logic             protectError
);

   pwbi_pkg::pwbi_state_e state_q;
   pwbi_pkg::pwbi_state_e state_d;
   logic [15:0] scratch_q;
   logic [15:0] scratch_d;
   logic [15:0] count_q;
   logic [15:0] count_d;
   logic [15:0] mAddr_q;
   logic [15:0] mAddr_d;
   logic [15:0] pc_q;
   logic [15:0] pc_d;
   logic [1:0]  hold_q;
   logic [1:0]  hold_d;
   logic        strobe_q;
   logic        strobe_d;
   logic        busy_q;
   logic        busy_d;
   logic [15:0] accA_q;
   logic [15:0] accA_d;
   logic [15:0] accB_q;
   logic [15:0] accB_d;
   logic [15:0] pcOut_q;
   logic [15:0] pcOut_d;
   logic        fetchReq_q;
   logic        fetchReq_d;
   logic [15:0] fetchAddr_q;
   logic [15:0] fetchAddr_d;
   logic        intExit_q;
   logic        intExit_d;
   logic        protErr_q;
   logic        protErr_d;
   logic        rdySync1_q;
   logic        rdySync2_q;
   logic [15:0] datSync1_q;
   logic [15:0] datSync2_q;
   logic        violation;
   logic        push;
   logic        bufReady;
   logic        bufEmpty;
   logic [31:0] bufOut;

   // Pin synchronisers; first stage feeds only the second
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         rdySync1_q <= 1'b1;
         rdySync2_q <= 1'b1;
         datSync1_q <= pwbi_pkg::WORD_ZERO;
         datSync2_q <= pwbi_pkg::WORD_ZERO;
      end else begin
         rdySync1_q <= portDataReady_n;
         rdySync2_q <= rdySync1_q;
         datSync1_q <= portBusIn;
         datSync2_q <= datSync1_q;
      end
   end

   // Write target below the fence or rejected by the map
   assign violation = (mAddr_q < fenceAddr) || mapViolation;

   // Sequencer next state
   always_comb begin
      state_d     = state_q;
      scratch_d   = scratch_q;
      count_d     = count_q;
      mAddr_d     = mAddr_q;
      pc_d        = pc_q;
      hold_d      = hold_q;
      strobe_d    = 1'b0;
      busy_d      = busy_q;
      accA_d      = accA_q;
      accB_d      = accB_q;
      pcOut_d     = pcOut_q;
      fetchReq_d  = 1'b0;
      fetchAddr_d = fetchAddr_q;
      intExit_d   = 1'b0;
      protErr_d   = 1'b0;
      push        = 1'b0;
      case (state_q)
         pwbi_pkg::S_IDLE: begin
            if (burstStart) begin
               scratch_d = pcIn;
               count_d   = accAIn;
               mAddr_d   = accBIn;
               busy_d    = 1'b1;
               // Zero count skips straight to the exit
               state_d   = (accAIn == pwbi_pkg::WORD_ZERO) ? pwbi_pkg::S_DONE : pwbi_pkg::S_WAIT_INT;
            end
         end
         pwbi_pkg::S_WAIT_INT: begin
            state_d = intPending ? pwbi_pkg::S_INTR : pwbi_pkg::S_WAIT_RDY;
         end
         pwbi_pkg::S_WAIT_RDY: begin
            // Ready is sampled after two flops; a glitchy ready just loops again
            state_d = !rdySync2_q ? pwbi_pkg::S_LOAD : pwbi_pkg::S_WAIT_INT;
         end
         pwbi_pkg::S_LOAD: begin
            mAddr_d  = mAddr_q;
            pc_d     = mAddr_q + pwbi_pkg::ADDR_STEP;
            hold_d   = pwbi_pkg::HOLD_ZERO;
            strobe_d = 1'b1;
            state_d  = pwbi_pkg::S_BURST;
         end
         pwbi_pkg::S_BURST: begin
            strobe_d = 1'b1;
            if (hold_q != pwbi_pkg::STROBE_LAST) begin
               hold_d = hold_q + 2'h1;
            end else if (violation) begin
               // Abort without storing; software restarts from re-entry
               strobe_d  = 1'b0;
               protErr_d = 1'b1;
               pcOut_d   = scratch_q;
               accA_d    = count_q;
               accB_d    = mAddr_q;
               busy_d    = 1'b0;
               state_d   = pwbi_pkg::S_IDLE;
            end else if (bufReady) begin
               push     = 1'b1;
               strobe_d = 1'b0;
               state_d  = pwbi_pkg::S_STEP;
            end
         end
         pwbi_pkg::S_STEP: begin
            count_d = count_q - pwbi_pkg::ADDR_STEP;
            mAddr_d = pc_q;
            pc_d    = pc_q + pwbi_pkg::ADDR_STEP;
            state_d = pwbi_pkg::S_TEST;
         end
         pwbi_pkg::S_TEST: begin
            if (count_q != pwbi_pkg::WORD_ZERO) begin
               hold_d   = pwbi_pkg::HOLD_ZERO;
               strobe_d = 1'b1;
               state_d  = pwbi_pkg::S_BURST;
            end else begin
               state_d = pwbi_pkg::S_DONE;
            end
         end
         pwbi_pkg::S_DONE: begin
            // Hold completion until every word has reached memory
            if (bufEmpty) begin
               fetchReq_d  = 1'b1;
               fetchAddr_d = scratch_q;
               pcOut_d     = scratch_q + pwbi_pkg::ADDR_STEP;
               accA_d      = pwbi_pkg::WORD_ZERO;
               accB_d      = mAddr_q;
               busy_d      = 1'b0;
               state_d     = pwbi_pkg::S_IDLE;
            end
         end
         pwbi_pkg::S_INTR: begin
            pcOut_d   = scratch_q;
            accA_d    = count_q;
            accB_d    = mAddr_q;
            intExit_d = 1'b1;
            busy_d    = 1'b0;
            state_d   = pwbi_pkg::S_IDLE;
         end
         default: begin
            busy_d  = 1'b0;
            state_d = pwbi_pkg::S_IDLE;
         end
      endcase
   end

   // Sequencer registers
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q     <= pwbi_pkg::S_IDLE;
         scratch_q   <= pwbi_pkg::WORD_ZERO;
         count_q     <= pwbi_pkg::WORD_ZERO;
         mAddr_q     <= pwbi_pkg::WORD_ZERO;
         pc_q        <= pwbi_pkg::WORD_ZERO;
         hold_q      <= pwbi_pkg::HOLD_ZERO;
         strobe_q    <= 1'b0;
         busy_q      <= 1'b0;
         accA_q      <= pwbi_pkg::WORD_ZERO;
         accB_q      <= pwbi_pkg::WORD_ZERO;
         pcOut_q     <= pwbi_pkg::WORD_ZERO;
         fetchReq_q  <= 1'b0;
         fetchAddr_q <= pwbi_pkg::WORD_ZERO;
         intExit_q   <= 1'b0;
         protErr_q   <= 1'b0;
      end else begin
         state_q     <= state_d;
         scratch_q   <= scratch_d;
         count_q     <= count_d;
         mAddr_q     <= mAddr_d;
         pc_q        <= pc_d;
         hold_q      <= hold_d;
         strobe_q    <= strobe_d;
         busy_q      <= busy_d;
         accA_q      <= accA_d;
         accB_q      <= accB_d;
         pcOut_q     <= pcOut_d;
         fetchReq_q  <= fetchReq_d;
         fetchAddr_q <= fetchAddr_d;
         intExit_q   <= intExit_d;
         protErr_q   <= protErr_d;
      end
   end

   // Word buffer so a stalled memory loses nothing
   pwbi_skid_buf #(
      .WIDTH(pwbi_pkg::ADDR_W + pwbi_pkg::DATA_W)
   ) u_buf (
      .sys_clk  (sys_clk),
      .reset_n  (reset_n),
      .inValid  (push),
      .inReady  (bufReady),
      .inData   ({mAddr_q, datSync2_q}),
      .outValid (memWrite),
      .outReady (memReady),
      .outData  (bufOut),
      .empty    (bufEmpty)
   );

   // Output wiring, all from flops
   assign memAddr             = bufOut[31:16];
   assign memData             = bufOut[15:0];
   assign portBusEnableStrobe = strobe_q;
   assign busy                = busy_q;
   assign accAOut             = accA_q;
   assign accBOut             = accB_q;
   assign pcOut               = pcOut_q;
   assign fetchReq            = fetchReq_q;
   assign fetchAddr           = fetchAddr_q;
   assign intExit             = intExit_q;
   assign protectError        = protErr_q;

   // Checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   a_entry_saves_pc: assert property (
      state_q == pwbi_pkg::S_IDLE && burstStart |=> scratch_q == $past(pcIn) && busy)
      else $error("re-entry address not saved");
   a_count_loaded: assert property (
      state_q == pwbi_pkg::S_IDLE && burstStart |=> count_q == $past(accAIn))
      else $error("word count not loaded");
   a_int_branch: assert property (
      state_q == pwbi_pkg::S_WAIT_INT && intPending |=> state_q == pwbi_pkg::S_INTR ##1 intExit)
      else $error("pending interrupt not taken");
   a_ready_poll: assert property (
      state_q == pwbi_pkg::S_WAIT_RDY && rdySync2_q |=> state_q == pwbi_pkg::S_WAIT_INT)
      else $error("proceeded without data ready");
   a_load_addr: assert property (
      state_q == pwbi_pkg::S_LOAD |=> pc_q == mAddr_q + pwbi_pkg::ADDR_STEP && strobe_q)
      else $error("first address load wrong");
   a_protect_abort: assert property (
      state_q == pwbi_pkg::S_BURST && hold_q == pwbi_pkg::STROBE_LAST && violation
      |-> !push ##1 protectError && state_q == pwbi_pkg::S_IDLE)
      else $error("violation not flagged or word stored");
   a_strobe_burst: assert property (
      state_q == pwbi_pkg::S_BURST |-> portBusEnableStrobe)
      else $error("strobe low during word transfer");
   a_mem_hold: assert property (
      memWrite && !memReady |=> memWrite && $stable(memAddr) && $stable(memData))
      else $error("memory write dropped under stall");
   a_step_update: assert property (
      state_q == pwbi_pkg::S_STEP |=> count_q == $past(count_q) - pwbi_pkg::ADDR_STEP
      && mAddr_q == $past(pc_q) && pc_q == $past(pc_q) + pwbi_pkg::ADDR_STEP)
      else $error("per-word update wrong");
   a_loop_back: assert property (
      state_q == pwbi_pkg::S_TEST && count_q != pwbi_pkg::WORD_ZERO |=> state_q == pwbi_pkg::S_BURST)
      else $error("loop left with count non-zero");
   a_done_fetch: assert property (
      fetchReq |-> fetchAddr == scratch_q && accAOut == pwbi_pkg::WORD_ZERO && !busy)
      else $error("completion outputs wrong");
   a_int_restore: assert property (
      intExit |-> pcOut == scratch_q && !busy)
      else $error("re-entry address not restored");

   c_burst_done: cover property (fetchReq && $past(state_q) == pwbi_pkg::S_DONE);
   c_int_exit: cover property (intExit);
   c_protect_abort: cover property (protectError);
   c_mem_stall: cover property (memWrite && !memReady ##1 memWrite && memReady);

endmodule

// ==== design/pwbi_pkg.sv ====
package pwbi_pkg;

   // Datapath widths
   localparam int DATA_W = 16;
   localparam int ADDR_W = 16;

   // Reset values
   localparam logic [15:0] WORD_ZERO = 16'h0000;
   localparam logic [1:0]  HOLD_ZERO = 2'h0;

   // Address step between successive buffer words
   localparam logic [15:0] ADDR_STEP = 16'h0001;

   // Strobe hold: two cycles of pin synchroniser plus the capture cycle
   localparam int          SYNC_STAGES = 2;
   localparam logic [1:0]  STROBE_LAST = 2'h2;

   // Sequencer states, one-hot
   typedef enum logic [8:0] {
      S_IDLE     = 9'h001,
      S_WAIT_INT = 9'h002,
      S_WAIT_RDY = 9'h004,
      S_LOAD     = 9'h008,
      S_BURST    = 9'h010,
      S_STEP     = 9'h020,
      S_TEST     = 9'h040,
      S_DONE     = 9'h080,
      S_INTR     = 9'h100
   } pwbi_state_e;

endpackage

// ==== design/pwbi_skid_buf.sv ====
`timescale 1ns/100ps

// Two-entry buffer: output register plus one skid slot
module pwbi_skid_buf #(
   parameter int WIDTH = 32
) (
   // Clock and reset
   input  wire logic             sys_clk,
   input  wire logic             reset_n,
   // Filling side
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   // Draining side
   output logic                  outValid,
   input  wire logic             outReady,
   output logic [WIDTH-1:0]      outData,
   // Status
   output logic                  empty
);

   logic             outValid_q;
   logic             outValid_d;
   logic [WIDTH-1:0] outData_q;
   logic [WIDTH-1:0] outData_d;
   logic             skidValid_q;
   logic             skidValid_d;
   logic [WIDTH-1:0] skidData_q;
   logic [WIDTH-1:0] skidData_d;

   // Ready only from flops, so the source never sees a combinational loop
   assign inReady  = !skidValid_q;
   assign outValid = outValid_q;
   assign outData  = outData_q;
   assign empty    = !outValid_q && !skidValid_q;

   // Next entry contents
   always_comb begin
      outValid_d  = outValid_q;
      outData_d   = outData_q;
      skidValid_d = skidValid_q;
      skidData_d  = skidData_q;
      if (outReady || !outValid_q) begin
         if (skidValid_q) begin
            outValid_d  = 1'b1;
            outData_d   = skidData_q;
            skidValid_d = 1'b0;
         end else begin
            outValid_d = inValid;
            outData_d  = inData;
         end
      end else if (inValid && !skidValid_q) begin
         // Drain stalled: park the word instead of dropping it
         skidValid_d = 1'b1;
         skidData_d  = inData;
      end
   end

   // Entry registers
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         outValid_q  <= 1'b0;
         outData_q   <= '0;
         skidValid_q <= 1'b0;
         skidData_q  <= '0;
      end else begin
         outValid_q  <= outValid_d;
         outData_q   <= outData_d;
         skidValid_q <= skidValid_d;
         skidData_q  <= skidData_d;
      end
   end

endmodule

// ==== test/pwbi_port_dev.sv ====
`timescale 1ns/100ps

// Port-side device: offers one counted word per strobe period
module pwbi_port_dev (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        reset_n,
   // Bench control
   input  wire logic        devGo,
   input  wire logic [15:0] wordBase,
   // Port pins
   output logic             portDataReady_n,
   output logic [15:0]      portBusIn,
   input  wire logic        portBusEnableStrobe
);
   logic [15:0] idx_q;
   logic        strobe_q;
   logic        ready_q;

   // Ready is a register, so it holds through whole cycles
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         idx_q    <= 16'h0000;
         strobe_q <= 1'b0;
         ready_q  <= 1'b0;
      end else begin
         strobe_q <= portBusEnableStrobe;
         ready_q  <= devGo;
         if (!devGo)
            idx_q <= 16'h0000;
         else if (strobe_q && !portBusEnableStrobe)
            idx_q <= idx_q + 16'h0001;
      end
   end

   assign portDataReady_n = ~ready_q;
   // Released bus shows the inverse, so a stale sample never passes
   assign portBusIn = ready_q ? (wordBase + idx_q) : ~(wordBase + idx_q);
endmodule

// ==== test/tb_top.sv ====
`timescale 1ns/100ps

module tb_top;
   logic        sys_clk, reset_n, burstStart, intPending, mapViolation, memReady, devGo;
   logic [15:0] pcIn, accAIn, accBIn, fenceAddr, portBusIn, memAddr, memData;
   logic [15:0] accAOut, accBOut, pcOut, fetchAddr;
   logic        portDataReady_n, portBusEnableStrobe, memWrite, busy, fetchReq, intExit, protectError;
   logic [15:0] wAddr [0:15];
   logic [15:0] wData [0:15];
   logic        strobeQ;
   int          nWr, nStrobe, stallLeft, cycles, n_fail, n_tests;

   pwbi_burst_input pwbi_burst_input_inst (.sys_clk(sys_clk), .reset_n(reset_n), .burstStart(burstStart),
      .pcIn(pcIn), .accAIn(accAIn), .accBIn(accBIn), .intPending(intPending), .fenceAddr(fenceAddr),
      .mapViolation(mapViolation), .portDataReady_n(portDataReady_n), .portBusIn(portBusIn),
      .portBusEnableStrobe(portBusEnableStrobe), .memWrite(memWrite), .memReady(memReady),
      .memAddr(memAddr), .memData(memData), .busy(busy), .accAOut(accAOut), .accBOut(accBOut),
      .pcOut(pcOut), .fetchReq(fetchReq), .fetchAddr(fetchAddr), .intExit(intExit),
      .protectError(protectError));

   pwbi_port_dev pwbi_port_dev_inst (.sys_clk(sys_clk), .reset_n(reset_n), .devGo(devGo),
      .wordBase(16'ha500), .portDataReady_n(portDataReady_n), .portBusIn(portBusIn),
      .portBusEnableStrobe(portBusEnableStrobe));

   always #5 sys_clk = ~sys_clk;

   // Memory side records accepted writes and stalls when asked
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      strobeQ <= portBusEnableStrobe;
      if (portBusEnableStrobe === 1'b1 && strobeQ === 1'b0)
         nStrobe <= nStrobe + 1;
      if (memWrite === 1'b1 && memReady === 1'b1) begin
         wAddr[nWr] <= memAddr;
         wData[nWr] <= memData;
         nWr <= nWr + 1;
      end
      memReady <= (stallLeft <= 1);
      if (stallLeft > 0)
         stallLeft <= stallLeft - 1;
      if (cycles == 6000) begin
         n_fail++;
         give_verdict();
      end
   end

   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Start a burst; counters restart so each test sees only its own traffic
   task automatic start(input logic [15:0] pc, input logic [15:0] cnt, input logic [15:0] addr, input int stall);
      @(posedge sys_clk);
      devGo <= 1'b0;
      nWr <= 0;
      nStrobe <= 0;
      stallLeft <= stall;
      pcIn <= pc;
      accAIn <= cnt;
      accBIn <= addr;
      burstStart <= 1'b1;
      @(posedge sys_clk);
      burstStart <= 1'b0;
   endtask

   // Bounded wait for any of the three end pulses
   task automatic wait_end(input int goAfter);
      for (int k = 0; k < 400; k++) begin
         @(posedge sys_clk);
         if (k == goAfter)
            devGo <= 1'b1;
         #1;
         if (fetchReq === 1'b1 || intExit === 1'b1 || protectError === 1'b1)
            break;
      end
      check("busy at end", 16'h0000, {15'h0000, busy});
      // Drop ready here: two sync flops would carry a stale ready into the next burst
      devGo <= 1'b0;
   endtask

   // Full burst: ready arrives late, memory stalls to fill the buffer
   task automatic test_burst(input logic [15:0] cnt, input logic [15:0] addr, input int stall);
      start(16'h1234, cnt, addr, stall);
      wait_end(6);
      check("done pulse", 16'h0001, {15'h0000, fetchReq});
      check("fetch address", 16'h1234, fetchAddr);
      check("pc out", 16'h1235, pcOut);
      check("acc a", 16'h0000, accAOut);
      check("acc b", addr + cnt, accBOut);
      check("strobes", cnt, 16'(nStrobe));
      check("writes", cnt, 16'(nWr));
      for (int i = 0; i < int'(cnt) && i < 16; i++) begin
         check("write address", addr + 16'(i), wAddr[i]);
         check("write data", 16'ha500 + 16'(i), wData[i]);
      end
      $display("test burst of %0d words done", cnt);
   endtask

   // Zero count finishes without touching the port
   task automatic test_zero();
      start(16'h0777, 16'h0000, 16'h0300, 0);
      wait_end(2);
      check("done pulse", 16'h0001, {15'h0000, fetchReq});
      check("fetch address", 16'h0777, fetchAddr);
      check("acc a", 16'h0000, accAOut);
      check("strobes", 16'h0000, 16'(nStrobe));
      $display("test zero count done");
   endtask

   // Interrupt while waiting for ready takes the exit path
   task automatic test_intr();
      start(16'h2468, 16'h0003, 16'h0500, 0);
      repeat (5) @(posedge sys_clk);
      intPending <= 1'b1;
      wait_end(399);
      check("int exit", 16'h0001, {15'h0000, intExit});
      check("pc restored", 16'h2468, pcOut);
      check("acc a", 16'h0003, accAOut);
      check("strobes", 16'h0000, 16'(nStrobe));
      intPending <= 1'b0;
      $display("test interrupt exit done");
   endtask

   // Fence and mapping violations each abort the first write
   task automatic test_protect();
      for (int m = 0; m < 2; m++) begin
         start(16'h3300, 16'h0002, 16'h0040, 0);
         fenceAddr <= (m == 0) ? 16'h0041 : 16'h0000;
         mapViolation <= (m == 1);
         wait_end(1);
         check("protect pulse", 16'h0001, {15'h0000, protectError});
         check("writes", 16'h0000, 16'(nWr));
         check("pc restored", 16'h3300, pcOut);
      end
      fenceAddr <= 16'h0000;
      mapViolation <= 1'b0;
      $display("test protect abort done");
   endtask

   task automatic give_verdict();
      $display("Counts: %0d checks, %0d mismatches", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Reset, then the tests back to back
   initial begin
      sys_clk = 1'b0;
      reset_n = 1'b0;
      {burstStart, intPending, mapViolation, devGo} = 4'h0;
      {pcIn, accAIn, accBIn} = 48'h0;
      fenceAddr = 16'h0100;
      nWr = 0;
      nStrobe = 0;
      stallLeft = 0;
      cycles = 0;
      n_fail = 0;
      n_tests = 0;
      repeat (3) @(posedge sys_clk);
      reset_n <= 1'b1;
      test_burst(16'h0004, 16'h0100, 40);
      test_burst(16'h0001, 16'hfffe, 0);
      test_zero();
      test_intr();
      test_protect();
      give_verdict();
   end
endmodule
